// File: verilog/bmd_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the bus master config
// Assumes: Register select is a 3-bit register address port
// Notes: Definitions only
`ifndef BMD_MAP_SVH
`define BMD_MAP_SVH
`define BMD_ADDR_IBA_LOW 3'h3
`define BMD_ADDR_BMI_CFG 3'h4
`define BMD_IBA_LOW_RESET 16'h0000
`define BMD_CFG_RESET 16'h0000
`define BMD_CFG_BUS_RESET_MASK 16'hff84
`define BMD_F_TXWD_HI 15
`define BMD_F_TXWD_LO 14
`define BMD_F_RXWD_HI 13
`define BMD_F_RXWD_LO 12
`define BMD_F_ODD 11
`define BMD_F_HOLD 10
`define BMD_F_FWM_HI 9
`define BMD_F_FWM_LO 8
`define BMD_F_BAE 7
`define BMD_F_BUS_RELEASE_PIN_SELECT 6
`define BMD_F_BSWC 5
`define BMD_F_BURST_HI 4
`define BMD_F_BURST_LO 3
`define BMD_F_BSWD 2
`define BMD_F_ASP 1
`define BMD_F_BPC 0
`define BMD_WD_EXP_1 20'h4_0000
`define BMD_WD_EXP_2 21'h08_0000
`define BMD_WD_EXP_3 21'h10_0000
`define BMD_PRIM_WD_EXPIRED 4'h3
`define BMD_FWM_N_00 6'h19
`define BMD_FWM_N_01 6'h11
`define BMD_FWM_N_10 6'h09
`define BMD_HOLD_N_00 6'h03
`define BMD_HOLD_N_01 6'h0b
`define BMD_HOLD_N_10 6'h13
`define BMD_BURST_1 6'h01
`define BMD_BURST_8 6'h08
`define BMD_BURST_UNL 6'h00
`endif

// File: verilog/bmd_pkg.sv
// Purpose: Types of the bus master config block
// Assumes: Constants live in bmd_map.svh
// Notes: None
package bmd_pkg;
	typedef struct packed {
		logic [1:0] tx_watchdog_select;
		logic [1:0] rx_watchdog_select;
		logic rx_odd_align;
		logic tx_holdoff_enable;
		logic [1:0] fifo_watermark;
		logic upper_addr_drive_enable;
		logic bus_release_pin_select;
		logic control_byte_swap;
		logic [1:0] burst;
		logic data_byte_swap;
		logic addr_strobe_polarity;
		logic byte_pin_control;
	} bmd_cfg_t;
	typedef struct packed {
		logic [5:0] tx_level;
		logic [5:0] tx_free;
		logic [5:0] rx_level;
		logic rx_frame_end;
		logic tx_frame_whole;
	} bmd_fifo_t;
endpackage : bmd_pkg

// File: verilog/bmd_watchdog.sv
// Purpose: One data clock watchdog
// Assumes: Clock pin sampled through three flip-flops
// Notes: Restarts on every edge of the sampled clock
`include "bmd_map.svh"
module bmd_watchdog import bmd_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic data_clk,
	input wire logic [1:0] sel,
	output logic expired
);
	logic [2:0] sync_reg;
	logic [2:0] sync_next;
	logic [20:0] cnt_reg;
	logic [20:0] cnt_next;
	logic exp_reg;
	logic exp_next;
	logic [20:0] limit;
	always_comb begin
		sync_next = {sync_reg[1:0], data_clk};
		case (sel)
			2'h1: limit = {1'b0, `BMD_WD_EXP_1};
			2'h2: limit = `BMD_WD_EXP_2;
			2'h3: limit = `BMD_WD_EXP_3;
			default: limit = 21'h00_0000;
		endcase
		cnt_next = cnt_reg;
		exp_next = 1'b0;
		if (sel == 2'h0) begin
			cnt_next = 21'h00_0000;
		end else if (sync_reg[2] != sync_reg[1]) begin
			cnt_next = 21'h00_0000;
		end else if (cnt_reg == limit - 21'h00_0001) begin
			cnt_next = 21'h00_0000;
			exp_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + 21'h00_0001;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_reg <= 3'h0;
			cnt_reg <= 21'h00_0000;
			exp_reg <= 1'b0;
		end else begin
			sync_reg <= sync_next;
			cnt_reg <= cnt_next;
			exp_reg <= exp_next;
		end
	end
	assign expired = exp_reg;
endmodule : bmd_watchdog

// File: verilog/bmd_bus_master_dma_config.sv
// Purpose: Bus master interface configuration and its effect on DMA and pins
// Assumes: Register port with 3-bit select, the rest of the controller around it
// Notes: Bus reset clears the documented fields of the config register
//
// How it works
// - Init address low joins upper byte
// - Two-bit watchdog selects, 00 disables
// - Watchdogs restart on data clock edges
// - Expiry reports provider primitive code three
// - Odd align duplicates first received byte
// - Hold-off waits for count or frame
// - Receive DMA waits for watermark or end
// - Transmit fetch needs watermark free space
// - Upper address drive or follow lower
// - Bus release pin or byte pin
// - Control swap orders non-data accesses
// - Data swap orders data buffer accesses
// - Burst field limits transfers per tenure
// - Address strobe polarity by control bit
// - Byte control selects pin functions
`include "bmd_map.svh"
module bmd_bus_master_dma_config import bmd_pkg::*; (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic REG_WR,
	input wire logic [2:0] REG_SEL,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	input wire logic [7:0] INIT_ADDR_HIGH,
	output logic [23:0] INIT_BLOCK_BASE,
	input wire logic TX_DATA_CLOCK,
	input wire logic RX_DATA_CLOCK,
	output logic PRIM_VALID,
	output logic [3:0] PRIM_CODE,
	input wire bmd_fifo_t FIFO_STATE,
	output logic RX_DMA_ALLOW,
	output logic TX_FETCH_ALLOW,
	output logic TX_START_ALLOW,
	input wire logic RX_FIRST_BYTE,
	input wire logic [7:0] RX_BYTE,
	output logic [15:0] RX_FIRST_WORD,
	input wire logic DMA_DATA_XFER,
	input wire logic [15:0] DMA_WORD_INT,
	output logic [15:0] DMA_WORD_MEM,
	output logic [5:0] BURST_LIMIT,
	input wire logic BUS_MASTER,
	input wire logic ADDR_STROBE_INT,
	output logic ADDR_STROBE_PIN,
	input wire logic [23:16] ADDR_INT,
	input wire logic ADDR_PHASE,
	output logic [23:20] ADDR_HIGH_PIN,
	output logic ADDR_HIGH_OE,
	input wire logic [1:0] BYTE_MASK_INT,
	input wire logic BYTE_SEL_INT,
	input wire logic BUS_ACK_INT,
	input wire logic BUS_REQ_INT,
	input wire logic BUS_RELEASE_PIN_IN,
	output logic BUS_RELEASE_INPUT,
	output logic BYTE_MASK_LOW_OUT,
	output logic BYTE_MASK_LOW_OE,
	output logic BYTE_MASK_HIGH,
	output logic HOLD_OR_REQUEST
);
	//////////////////////////////////////////////////////////////////////////////////
	logic [15:0] iba_reg;
	logic [15:0] iba_next;
	logic [15:0] cfg_reg;
	logic [15:0] cfg_next;
	bmd_cfg_t cfg;
	logic tx_exp;
	logic rx_exp;
	logic prim_reg;
	logic prim_next;
	logic [2:0] brel_reg;
	logic [2:0] brel_next;
	logic brel_state_reg;
	logic brel_state_next;
	logic [15:0] rxw_reg;
	logic [15:0] rxw_next;
	logic [15:0] dmaw_reg;
	logic [15:0] dmaw_next;
	logic [5:0] fwm_n;
	logic [5:0] hold_n;

	function automatic logic [15:0] bmd_swap(input logic [15:0] w, input logic sw);
		bmd_swap = sw ? {w[7:0], w[15:8]} : w;
	endfunction : bmd_swap

	assign cfg = cfg_reg;

	//////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		iba_next = iba_reg;
		cfg_next = cfg_reg;
		if (REG_WR && REG_SEL == `BMD_ADDR_IBA_LOW) begin
			iba_next = REG_WDATA;
		end
		if (REG_WR && REG_SEL == `BMD_ADDR_BMI_CFG) begin
			cfg_next = REG_WDATA;
		end
	end

	always_comb begin
		case (REG_SEL)
			`BMD_ADDR_IBA_LOW: REG_RDATA = iba_reg;
			`BMD_ADDR_BMI_CFG: REG_RDATA = cfg_reg;
			default: REG_RDATA = 16'h0000;
		endcase
	end

	assign INIT_BLOCK_BASE = {INIT_ADDR_HIGH, iba_reg};

	//////////////////////////////////////////////////////////////////////////////////
	bmd_watchdog u_tx_wd (
		.clk(REF_CLK),
		.rst(RESET),
		.data_clk(TX_DATA_CLOCK),
		.sel(cfg.tx_watchdog_select),
		.expired(tx_exp)
	);
	bmd_watchdog u_rx_wd (
		.clk(REF_CLK),
		.rst(RESET),
		.data_clk(RX_DATA_CLOCK),
		.sel(cfg.rx_watchdog_select),
		.expired(rx_exp)
	);

	always_comb begin
		prim_next = tx_exp | rx_exp;
	end
	assign PRIM_VALID = prim_reg;
	assign PRIM_CODE = prim_reg ? `BMD_PRIM_WD_EXPIRED : 4'h0;

	//////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		case (cfg.fifo_watermark)
			2'h0: fwm_n = `BMD_FWM_N_00;
			2'h1: fwm_n = `BMD_FWM_N_01;
			2'h2: fwm_n = `BMD_FWM_N_10;
			default: fwm_n = `BMD_FWM_N_10;
		endcase
		case (cfg.fifo_watermark)
			2'h0: hold_n = `BMD_HOLD_N_00;
			2'h1: hold_n = `BMD_HOLD_N_01;
			2'h2: hold_n = `BMD_HOLD_N_10;
			default: hold_n = `BMD_HOLD_N_10;
		endcase
		case (cfg.burst)
			2'h0: BURST_LIMIT = `BMD_BURST_1;
			2'h2: BURST_LIMIT = `BMD_BURST_8;
			2'h1: BURST_LIMIT = `BMD_BURST_UNL;
			default: BURST_LIMIT = `BMD_BURST_1;
		endcase
	end

	assign RX_DMA_ALLOW = (FIFO_STATE.rx_level >= fwm_n) || FIFO_STATE.rx_frame_end;
	assign TX_FETCH_ALLOW = FIFO_STATE.tx_free >= fwm_n;
	assign TX_START_ALLOW = !cfg.tx_holdoff_enable || (FIFO_STATE.tx_level >= hold_n)
		|| FIFO_STATE.tx_frame_whole;

	//////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		rxw_next = rxw_reg;
		dmaw_next = dmaw_reg;
		if (RX_FIRST_BYTE) begin
			rxw_next = cfg.rx_odd_align ? {RX_BYTE, RX_BYTE} : {8'h00, RX_BYTE};
		end
		if (DMA_DATA_XFER) begin
			dmaw_next = bmd_swap(DMA_WORD_INT, !cfg.data_byte_swap);
		end else begin
			dmaw_next = bmd_swap(DMA_WORD_INT, !cfg.control_byte_swap);
		end
	end
	assign RX_FIRST_WORD = rxw_reg;
	assign DMA_WORD_MEM = dmaw_reg;

	//////////////////////////////////////////////////////////////////////////////////
	assign ADDR_STROBE_PIN = BUS_MASTER ? (ADDR_STROBE_INT ^ cfg.addr_strobe_polarity)
		: 1'b0;
	// Value is always the upper address; only the drive timing follows the enable
	assign ADDR_HIGH_PIN = ADDR_INT[23:20];
	assign ADDR_HIGH_OE = cfg.upper_addr_drive_enable | (BUS_MASTER & ADDR_PHASE);

	always_comb begin
		brel_next = {brel_reg[1:0], BUS_RELEASE_PIN_IN};
		brel_state_next = brel_state_reg;
		if (brel_reg[2] == brel_reg[1]) begin
			brel_state_next = brel_reg[2];
		end
	end
	assign BUS_RELEASE_INPUT = cfg.bus_release_pin_select & brel_state_reg;
	assign BYTE_MASK_LOW_OE = !cfg.bus_release_pin_select;
	assign BYTE_MASK_LOW_OUT = cfg.byte_pin_control ? BYTE_SEL_INT : BYTE_MASK_INT[0];
	assign BYTE_MASK_HIGH = cfg.byte_pin_control ? BUS_ACK_INT : BYTE_MASK_INT[1];
	assign HOLD_OR_REQUEST = BUS_REQ_INT;

	//////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			iba_reg <= `BMD_IBA_LOW_RESET;
			cfg_reg <= cfg_reg & `BMD_CFG_BUS_RESET_MASK;
			prim_reg <= 1'b0;
			brel_reg <= 3'h0;
			brel_state_reg <= 1'b0;
			rxw_reg <= 16'h0000;
			dmaw_reg <= 16'h0000;
		end else begin
			iba_reg <= iba_next;
			cfg_reg <= cfg_next;
			prim_reg <= prim_next;
			brel_reg <= brel_next;
			brel_state_reg <= brel_state_next;
			rxw_reg <= rxw_next;
			dmaw_reg <= dmaw_next;
		end
	end
endmodule : bmd_bus_master_dma_config

// File: verification/bmd_cfg_monitor.sv
// Purpose: Port checker for the bus master config block
// Assumes: Config is visible on REG_RDATA while select is 4
// Notes: Bound to the top module
module bmd_cfg_monitor import bmd_pkg::*; (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic REG_WR,
	input wire logic [2:0] REG_SEL,
	input wire logic [15:0] REG_WDATA,
	input wire logic [15:0] REG_RDATA,
	input wire logic [23:0] INIT_BLOCK_BASE,
	input wire logic PRIM_VALID,
	input wire logic [3:0] PRIM_CODE,
	input wire bmd_fifo_t FIFO_STATE,
	input wire logic RX_DMA_ALLOW,
	input wire logic TX_FETCH_ALLOW,
	input wire logic [5:0] BURST_LIMIT,
	input wire logic BUS_MASTER,
	input wire logic ADDR_STROBE_INT,
	input wire logic ADDR_STROBE_PIN,
	input wire logic ADDR_PHASE,
	input wire logic ADDR_HIGH_OE,
	input wire logic BYTE_MASK_LOW_OE,
	input wire logic BUS_RELEASE_INPUT
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	logic cfg_on;
	logic [15:0] cfg;
	assign cfg_on = REG_SEL == 3'h4;
	assign cfg = REG_RDATA;
	////////////////////////////////////////////////////////////////////////////////
	a_base_join: assert property (
		REG_WR && REG_SEL == 3'h3 |=> INIT_BLOCK_BASE[15:0] == $past(REG_WDATA))
		else $error("init base low half wrong");
	a_prim_code: assert property (
		PRIM_VALID |-> PRIM_CODE == 4'h3 ##1 !PRIM_VALID)
		else $error("primitive code wrong");
	a_rx_gate: assert property (
		cfg_on && cfg[9:8] == 2'h2 |-> RX_DMA_ALLOW ==
		(FIFO_STATE.rx_level >= 6'h09 || FIFO_STATE.rx_frame_end))
		else $error("receive gate wrong");
	a_tx_fetch: assert property (
		cfg_on && cfg[9:8] == 2'h1 |-> TX_FETCH_ALLOW == (FIFO_STATE.tx_free >= 6'h11))
		else $error("transmit fetch gate wrong");
	a_upper_oe: assert property (
		cfg_on |-> ADDR_HIGH_OE == (cfg[7] || (BUS_MASTER && ADDR_PHASE)))
		else $error("upper address enable wrong");
	a_release_pin: assert property (
		cfg_on |-> BYTE_MASK_LOW_OE == !cfg[6] && (cfg[6] || !BUS_RELEASE_INPUT))
		else $error("release pin select wrong");
	a_burst_code: assert property (
		cfg_on |-> BURST_LIMIT == (cfg[4:3] == 2'h2 ? 6'h08 : cfg[4:3] == 2'h1 ? 6'h00 : 6'h01))
		else $error("burst limit wrong");
	a_strobe_level: assert property (
		cfg_on && BUS_MASTER |-> ADDR_STROBE_PIN == (ADDR_STROBE_INT ^ cfg[1]))
		else $error("address strobe level wrong");
	c_init_write: cover property (REG_WR && REG_SEL == 3'h3);
	c_rx_allow: cover property (cfg_on && RX_DMA_ALLOW);
	c_strobe_low: cover property (cfg_on && BUS_MASTER && cfg[1]);
endmodule : bmd_cfg_monitor
////////////////////////////////////////////////////////////////////////////////
bind bmd_bus_master_dma_config bmd_cfg_monitor i_mon (.REF_CLK(REF_CLK), .RESET(RESET),
	.REG_WR(REG_WR), .REG_SEL(REG_SEL), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.INIT_BLOCK_BASE(INIT_BLOCK_BASE), .PRIM_VALID(PRIM_VALID), .PRIM_CODE(PRIM_CODE),
	.FIFO_STATE(FIFO_STATE), .RX_DMA_ALLOW(RX_DMA_ALLOW), .TX_FETCH_ALLOW(TX_FETCH_ALLOW),
	.BURST_LIMIT(BURST_LIMIT), .BUS_MASTER(BUS_MASTER), .ADDR_STROBE_INT(ADDR_STROBE_INT),
	.ADDR_STROBE_PIN(ADDR_STROBE_PIN), .ADDR_PHASE(ADDR_PHASE), .ADDR_HIGH_OE(ADDR_HIGH_OE),
	.BYTE_MASK_LOW_OE(BYTE_MASK_LOW_OE), .BUS_RELEASE_INPUT(BUS_RELEASE_INPUT));

// File: verification/bmd_far_model.sv
// Purpose: Far side model making the data clocks
// Assumes: 160 ns period, phase unrelated to the system clock
// Notes: Clocks stand still outside frames
module bmd_far_model (
	input wire logic frame_on,
	output logic tx_clk,
	output logic rx_clk
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		tx_clk = 1'h0;
		rx_clk = 1'h1;
		#7.3;
		forever begin
			#80;
			if (frame_on) begin
				tx_clk = ~tx_clk;
				rx_clk = ~rx_clk;
			end
		end
	end
endmodule : bmd_far_model

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the bus master config block
// Assumes: Inputs change at the falling clock edge
// Notes: Watchdog expiry spans are far longer than this run
module tb_top import bmd_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, wr, frame_on, rx_ok, txf_ok, txs_ok, tx_clk, rx_clk;
	logic prim_v, strobe, oe_hi, bri, bm_lo, bm_lo_oe, bm_hi, hold_rq;
	logic [3:0] prim_c, addr_hi;
	logic [15:0] ex;
	logic [5:0] n;
	logic [2:0] sel;
	logic [15:0] wdata, rdata, w, misc, mem_word, first_word;
	logic [23:0] base;
	logic [5:0] burst;
	bmd_fifo_t fifo;
	int fail_count, checked, i;
	logic [5:0] nf [3] = '{6'h19, 6'h11, 6'h09};
	logic [5:0] hn [3] = '{6'h03, 6'h0b, 6'h13};
	logic [5:0] bl [3] = '{6'h01, 6'h00, 6'h08};
	bmd_far_model i_far (.frame_on(frame_on), .tx_clk(tx_clk), .rx_clk(rx_clk));
	bmd_bus_master_dma_config i_dut (.REF_CLK(clk), .RESET(rst), .REG_WR(wr),
		.REG_SEL(sel), .REG_WDATA(wdata), .REG_RDATA(rdata), .INIT_ADDR_HIGH(w[15:8]),
		.INIT_BLOCK_BASE(base), .TX_DATA_CLOCK(tx_clk), .RX_DATA_CLOCK(rx_clk),
		.PRIM_VALID(prim_v), .PRIM_CODE(prim_c), .FIFO_STATE(fifo), .RX_DMA_ALLOW(rx_ok),
		.TX_FETCH_ALLOW(txf_ok), .TX_START_ALLOW(txs_ok), .RX_FIRST_BYTE(misc[0]),
		.RX_BYTE(w[7:0]), .RX_FIRST_WORD(first_word), .DMA_DATA_XFER(misc[1]),
		.DMA_WORD_INT(w), .DMA_WORD_MEM(mem_word), .BURST_LIMIT(burst), .BUS_MASTER(misc[2]),
		.ADDR_STROBE_INT(misc[3]), .ADDR_STROBE_PIN(strobe), .ADDR_INT(w[15:8]),
		.ADDR_PHASE(misc[4]), .ADDR_HIGH_PIN(addr_hi), .ADDR_HIGH_OE(oe_hi),
		.BYTE_MASK_INT(misc[6:5]),
		.BYTE_SEL_INT(misc[7]), .BUS_ACK_INT(misc[8]), .BUS_REQ_INT(misc[9]),
		.BUS_RELEASE_PIN_IN(misc[10]), .BUS_RELEASE_INPUT(bri), .BYTE_MASK_LOW_OUT(bm_lo),
		.BYTE_MASK_LOW_OE(bm_lo_oe), .BYTE_MASK_HIGH(bm_hi), .HOLD_OR_REQUEST(hold_rq));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask : chk
	task automatic gate_chk(input string name, input logic [2:0] e);
		#1;
		chk(name, {7'h00, bl[i], e}, {7'h00, burst, rx_ok, txf_ok, txs_ok});
	endtask : gate_chk
	task automatic wr_reg(input logic [2:0] s, input logic [15:0] d);
		@(negedge clk);
		wr = 1'h1;
		sel = s;
		wdata = d;
		@(negedge clk);
		wr = 1'h0;
	endtask : wr_reg
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial begin
		#50us;
		fail_count++;
		complete_run();
	end
	initial begin
		rst = 1'h1;
		wr = 1'h0;
		sel = 3'h4;
		wdata = 16'h0000;
		w = 16'h0000;
		misc = 16'h0000;
		frame_on = 1'h0;
		fifo = '0;
		repeat (5) @(negedge clk);
		rst = 1'h0;
		wr_reg(3'h4, 16'hfef7);
		chk("config", 16'hfef7, rdata);
		rst = 1'h1;
		@(negedge clk);
		rst = 1'h0;
		#1;
		chk("config after reset", 16'hfe84, rdata);
		$display("Test reset done");
		w = 16'h5a00;
		wr_reg(3'h3, 16'h1234);
		chk("init base low", 16'h1234, base[15:0]);
		chk("init base high", 16'h005a, {8'h00, base[23:16]});
		sel = 3'h5;
		#1;
		chk("unmapped read", 16'h0000, rdata);
		$display("Test init address done");
		for (i = 0; i < 3; i++) begin
			wr_reg(3'h4, {5'h00, 1'h1, i[1:0], 3'h0, i[1:0], 3'h4});
			fifo = '{hn[i] - 6'h01, nf[i] - 6'h01, nf[i] - 6'h01, 1'h0, 1'h0};
			gate_chk("gates below", 3'h0);
			fifo = '{hn[i], nf[i], nf[i], 1'h0, 1'h0};
			gate_chk("gates at count", 3'h7);
			fifo = '{6'h00, 6'h00, 6'h00, 1'h1, 1'h1};
			gate_chk("gates at frame end", 3'h5);
		end
		$display("Test watermarks done");
		wr_reg(3'h4, 16'h0804);
		w = 16'habcd;
		misc = 16'h0003;
		@(negedge clk);
		chk("data word", 16'habcd, mem_word);
		chk("first word", 16'hcdcd, first_word);
		misc = 16'h0000;
		@(negedge clk);
		chk("control word", 16'hcdab, mem_word);
		$display("Test byte order done");
		frame_on = 1'h1;
		for (i = 0; i < 64; i++) begin
			wr_reg(3'h4, {6'h00, i[4], ~i[4], i[0], i[1], 4'h0, i[2], i[3]});
			misc = {i[3:0], i[5:0], i[5:0]};
			fifo = '{i[5:0], i[5:0], i[5:0] + 6'h03, i[1], i[2]};
			w = {i[3:0], ~i[3:0], 8'h00};
			// Let the release pin pass its three sampling stages
			repeat (4) @(negedge clk);
			n = i[4] ? 6'h09 : 6'h11;
			ex = {1'b0, i[2] ? (i[3] ^ i[2]) : 1'b0, w[15:12], i[0] | (i[2] & i[4]),
				i[3] ? misc[7] : misc[5], ~i[1], i[3] ? misc[8] : misc[6], misc[9],
				i[1] & misc[10], (i[5:0] + 6'h03 >= n) | i[1], i[5:0] >= n, 1'b1};
			chk("pin functions", ex, {prim_v, strobe, addr_hi, oe_hi, bm_lo, bm_lo_oe, bm_hi, hold_rq, bri, rx_ok, txf_ok, txs_ok});
		end
		frame_on = 1'h0;
		$display("Test pin functions done");
		complete_run();
	end
endmodule : tb_top
